/* File: include/adst_pkg.sv */
package adst_pkg;
  localparam int SMPL_FLD_W = 3;
  localparam int CVT_FLD_W = 5;
  localparam int CNT_W = 12;
  localparam int RES_W = 10;
  localparam logic [SMPL_FLD_W-1:0] SMPL_FLD_RESET = 3'h5;
  localparam logic [CVT_FLD_W-1:0] CVT_FLD_RESET = 5'h12;
  localparam logic MODE10_RESET = 1'b1;
  localparam logic [CNT_W-1:0] SMPL_MULT = 12'h008;
  localparam logic [CNT_W-1:0] SMPL_EXTRA = 12'h002;
  localparam logic [CNT_W-1:0] CVT_MULT = 12'h002;
  localparam logic [CNT_W-1:0] CVT_EXTRA = 12'h003;
  localparam logic [CNT_W-1:0] BITS_8 = 12'h008;
  localparam logic [CNT_W-1:0] BITS_10 = 12'h00a;
  typedef enum logic [1:0] {
    ADST_IDLE = 2'b00,
    ADST_SAMPLE = 2'b01,
    ADST_CONVERT = 2'b11
  } adst_state_t;
endpackage : adst_pkg

/* File: verilog/adst_timer.sv */
`timescale 1ns/1ps
module adst_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [adst_pkg::CNT_W-1:0] i_len,
  output logic o_done
);
  logic [adst_pkg::CNT_W-1:0] count;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= '0;
    end else if (i_load) begin
      count <= i_len;
    end else if (count != '0) begin
      count <= count - 12'h001;
    end
  end
  // one pulse on the last clock of the loaded length
  // no term on i_load here: the reload itself depends on this flag
  assign o_done = (count == 12'h001);
endmodule : adst_timer

/* File: verilog/adst_ctrl.sv */
`timescale 1ns/1ps
module adst_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_time_we,
  input wire logic [adst_pkg::SMPL_FLD_W-1:0] i_sample_length_field,
  input wire logic [adst_pkg::CVT_FLD_W-1:0] i_convert_length_field,
  input wire logic i_mode_10bit,
  input wire logic i_start,
  input wire logic [adst_pkg::RES_W-1:0] i_code,
  output logic o_busy,
  output logic o_sample_connect,
  output logic o_resolve,
  output logic [adst_pkg::RES_W-1:0] o_result,
  output logic o_done
);

  // controller state
  adst_pkg::adst_state_t state;
  adst_pkg::adst_state_t next_state;

  // latched timing setting, defined from reset on
  logic [adst_pkg::SMPL_FLD_W-1:0] sample_len;
  logic [adst_pkg::CVT_FLD_W-1:0] convert_length_field_len;
  logic mode10;

  // phase timer handshake
  logic timer_done;
  logic load;
  logic [adst_pkg::CNT_W-1:0] len;

  // comparator code synchroniser
  logic [adst_pkg::RES_W-1:0] code_meta;
  logic [adst_pkg::RES_W-1:0] code_sync;

  // state decode
  wire logic in_idle;
  wire logic in_sample;
  wire logic in_convert;
  wire logic start_ok;
  wire logic sample_end;
  wire logic convert_end;
  wire logic timing_write_ok;

  // sample length arithmetic
  wire logic [adst_pkg::CNT_W-1:0] sample_field_ext;
  wire logic [adst_pkg::CNT_W-1:0] sample_scaled;
  wire logic [adst_pkg::CNT_W-1:0] sample_cycles;

  // conversion length arithmetic
  wire logic [adst_pkg::CNT_W-1:0] bits;
  wire logic [adst_pkg::CNT_W-1:0] convert_length_field_field_ext;
  wire logic [adst_pkg::CNT_W-1:0] convert_length_field_units;
  wire logic [adst_pkg::CNT_W-1:0] convert_length_field_bit_units;
  wire logic [adst_pkg::CNT_W-1:0] convert_length_field_scaled;
  wire logic [adst_pkg::CNT_W-1:0] convert_length_field_cycles;

  // result formatting
  wire logic [adst_pkg::RES_W-1:0] code_8bit;
  wire logic [adst_pkg::RES_W-1:0] next_result;

  assign in_idle = (state == adst_pkg::ADST_IDLE);
  assign in_sample = (state == adst_pkg::ADST_SAMPLE);
  assign in_convert = (state == adst_pkg::ADST_CONVERT);

  assign o_sample_connect = in_sample;
  assign o_resolve = in_convert;
  assign o_busy = !in_idle;

  // request taken when idle
  // a start while busy is ignored, not queued
  assign start_ok = in_idle && i_start;
  assign sample_end = in_sample && timer_done;
  assign convert_end = in_convert && timer_done;

  // writes while idle
  // a write during conversion is dropped instead of corrupting the phase lengths
  assign timing_write_ok = i_time_we && in_idle;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sample_len <= adst_pkg::SMPL_FLD_RESET;
    end else if (timing_write_ok) begin
      sample_len <= i_sample_length_field;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      convert_length_field_len <= adst_pkg::CVT_FLD_RESET;
    end else if (timing_write_ok) begin
      convert_length_field_len <= i_convert_length_field;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode10 <= adst_pkg::MODE10_RESET;
    end else if (timing_write_ok) begin
      mode10 <= i_mode_10bit;
    end
  end

  assign bits = mode10 ? adst_pkg::BITS_10 : adst_pkg::BITS_8;

  // sample length
  // fields are not clipped: a zero field still gives two clocks
  assign sample_field_ext = {9'h000, sample_len};
  assign sample_scaled = 12'(adst_pkg::SMPL_MULT * sample_field_ext);
  assign sample_cycles = sample_scaled + adst_pkg::SMPL_EXTRA;

  // conversion length
  // worst case 2*10*32+3 fits the counter with room to spare
  assign convert_length_field_field_ext = {7'h00, convert_length_field_len};
  assign convert_length_field_units = convert_length_field_field_ext + 12'h001;
  assign convert_length_field_bit_units = 12'(bits * convert_length_field_units);
  assign convert_length_field_scaled = 12'(adst_pkg::CVT_MULT * convert_length_field_bit_units);
  assign convert_length_field_cycles = convert_length_field_scaled + adst_pkg::CVT_EXTRA;

  // timer reload at each phase entry
  // the reload lands on the edge that ends the sample phase, so no dead cycle
  assign load = start_ok || sample_end;
  assign len = sample_end ? convert_length_field_cycles : sample_cycles;

  always_comb begin
    next_state = state;
    unique case (state)
      adst_pkg::ADST_IDLE: begin
        if (start_ok) begin
          next_state = adst_pkg::ADST_SAMPLE;
        end
      end
      adst_pkg::ADST_SAMPLE: begin
        if (sample_end) begin
          next_state = adst_pkg::ADST_CONVERT;
        end
      end
      adst_pkg::ADST_CONVERT: begin
        if (convert_end) begin
          next_state = adst_pkg::ADST_IDLE;
        end
      end
      // the unused code falls back to idle
      default: begin
        next_state = adst_pkg::ADST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= adst_pkg::ADST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // phase timer
  adst_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(load),
    .i_len(len),
    .o_done(timer_done)
  );

  // comparator bits settle during resolve, long before the capture cycle,
  // so a plain two-flop stage per bit is safe here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      code_meta <= '0;
    end else begin
      code_meta <= i_code;
    end
  end

  // only this second stage is read by other logic
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      code_sync <= '0;
    end else begin
      code_sync <= code_meta;
    end
  end

  assign code_8bit = {code_sync[adst_pkg::RES_W-1:2], 2'b00};
  assign next_result = mode10 ? code_sync : code_8bit;

  // result presented
  // holds until the next conversion ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_result <= '0;
    end else if (convert_end) begin
      o_result <= next_result;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= convert_end;
    end
  end
endmodule : adst_ctrl

/* File: bench/adst_ctrl_sva.sv */
`timescale 1ns/1ps
module adst_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_sample_connect,
  input wire logic o_resolve,
  input wire logic o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a fall caused by reset is not a phase end
  sequence sample_phase_end;
    $fell(o_sample_connect) && !$past(i_rst);
  endsequence
  sequence resolve_phase_end;
    $fell(o_resolve) && !$past(i_rst);
  endsequence
  phase_excl_a: assert property (!(o_sample_connect && o_resolve)) else $error("phase overlap");
  start_sample_a: assert property (i_start && !o_busy |=> o_sample_connect) else $error("no sample");
  sample_min_a: assert property ($rose(o_sample_connect) |-> o_sample_connect[*8]) else $error("short sample");
  sample_next_a: assert property (sample_phase_end |-> o_resolve) else $error("no resolve");
  resolve_min_a: assert property ($rose(o_resolve) |-> o_resolve[*8]) else $error("short resolve");
  done_end_a: assert property (resolve_phase_end |-> o_done && !o_busy) else $error("no done");
  busy_phase_a: assert property (o_busy == (o_sample_connect || o_resolve)) else $error("busy wrong");
  done_pulse_a: assert property (o_done |=> !o_done) else $error("done long");
endmodule : adst_chk
bind adst_ctrl adst_chk u_chk (.*);

/* File: bench/tb_adst_ctrl.sv */
`timescale 1ns/1ps
module tb_adst_ctrl;
  logic i_clk = 0, i_rst = 1, i_time_we = 0, i_mode_10bit = 0, i_start = 0;
  logic [2:0] i_sample_length_field = 3'h0;
  logic [4:0] i_convert_length_field = 5'h0;
  logic [9:0] i_code = 10'h2b7;
  logic o_busy, o_sample_connect, o_resolve, o_done;
  logic [9:0] o_result;
  int mismatches = 0, samples_checked = 0, ns, nr;
  always #2.5 i_clk = ~i_clk;
  adst_ctrl u_dut (.*);
  task automatic chk(input string n, input logic [11:0] e, g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input logic w, m, p, input logic [2:0] s, input logic [4:0] c);
    @(negedge i_clk) {i_time_we, i_mode_10bit, i_sample_length_field, i_convert_length_field} = {w, m, s, c};
    @(negedge i_clk) {i_time_we, i_start} = 2'b01;
    @(negedge i_clk) i_start = 0;
    ns = 0;
    nr = 0;
    while (!o_done && nr < 2000) begin
      ns += o_sample_connect;
      nr += o_resolve;
      // rewrite and restart while busy must be ignored
      if (p && (ns == 3 || ns == 4)) begin
        {i_time_we, i_start, i_mode_10bit, i_sample_length_field, i_convert_length_field} =
          (ns == 3) ? {2'b11, !m, 3'h0, 5'h1f} : {2'b00, m, s, c};
      end
      @(negedge i_clk);
    end
    chk("sample", 8 * s + 2, ns);
    chk("resolve", 2 * (m ? 10 : 8) * (c + 1) + 3, nr);
    chk("result", m ? i_code : {i_code[9:2], 2'h0}, o_result);
    chk("busy", 0, o_busy);
    $display("test done");
  endtask : run
  task automatic reset_mid;
    @(negedge i_clk) i_start = 1;
    @(negedge i_clk) i_start = 0;
    repeat (4) @(negedge i_clk);
    chk("mid busy", 1, o_busy);
    i_rst = 1;
    @(negedge i_clk) i_rst = 0;
    chk("rst busy", 0, o_busy);
    chk("rst sample", 0, o_sample_connect);
    chk("rst done", 0, o_done);
    $display("test done");
  endtask : reset_mid
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 0;
    run(1'b0, 1'b1, 1'b0, 3'h5, 5'h12);
    run(1'b1, 1'b0, 1'b1, 3'h7, 5'h02);
    run(1'b1, 1'b1, 1'b0, 3'h1, 5'h1f);
    run(1'b1, 1'b0, 1'b1, 3'h1, 5'h1f);
    reset_mid;
    run(1'b0, 1'b1, 1'b0, 3'h5, 5'h12);
    print_verdict;
  end
  // nearly three times the expected run of about 2200 cycles
  initial begin
    #30000;
    mismatches++;
    print_verdict;
  end
endmodule : tb_adst_ctrl
